/* rtl/ljf_host_regs.sv */
// Serial host port, eight-register map, interrupt output and jitter attenuator FIFO.
`timescale 1ns/1ps
`default_nettype none
module ljf_host_regs #(
  parameter int DEPTH_MAX = 128
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Mode select and shared pins (serial port in host mode).
  input wire logic controlModeSelect,
  input wire logic shareCsIn,
  input wire logic shareSclkIn,
  input wire logic hostSerialIn,
  input wire logic shareSdoIn,
  output logic hostSerialOut,
  output logic hostSerialOutOe,
  input wire logic shareIntIn,
  output logic intOutN,
  output logic intOutOe,
  // Hardware-mode configuration pins.
  input wire logic transmitterEnable,
  input wire logic attenuatorPathSelect,
  input wire logic fifoSizeSelLow,
  input wire logic fifoSizeSelHigh,
  input wire logic transmitLevelSelect,
  input wire logic transmitAllOnes,
  input wire logic remoteLoopbackEn,
  input wire logic localLoopbackEn,
  input wire logic e3ModeSelect,
  input wire logic sonetOrT3RateSelect,
  input wire logic receiveEqualizerEn,
  // Alarm sources from the line blocks.
  input wire logic driverMonitorAlarm,
  input wire logic digitalSignalLoss,
  input wire logic analogSignalLoss,
  input wire logic receiveLockLoss,
  input wire logic patternLockLoss,
  input wire logic patternErrorPulse,
  // Line clocks and data.
  input wire logic transmitLineClock,
  input wire logic receiveLineClock,
  input wire logic transmitLineData,
  input wire logic receiveLineData,
  // Outputs to the line side.
  output logic dejitterClock,
  output logic dejitterData,
  output logic transmitDriveEn,
  output ljf_pkg::ljf_cfg_t lineCfg
);
  import ljf_pkg::*;

  localparam int PW = $clog2(DEPTH_MAX);

  ljf_pins_t rawPins, syncA_ff, syncB_ff, prev_ff;
  logic [7:0] redund_ff, irqEn_ff, irqSt_ff, txCtl_ff, rxCtl_ff, blkCtl_ff, jaCtl_ff;
  logic [7:0] nxt_irqSt, alarmVal, readVal, irqEvt, effIe;
  logic [7:0] shiftIn_ff, readShift_ff;
  logic [4:0] bitCnt_ff;
  logic [6:0] addr_ff;
  logic isRead_ff, fl_ff, nxt_fl;
  logic [15:0] errCnt_ff;
  logic [PW:0] wrPtr_ff, rdPtr_ff, fill;
  logic [7:0] depth, fill8;
  logic fifoMem [DEPTH_MAX];
  logic [$clog2(READ_DIV)-1:0] divCnt_ff;
  logic outClk_ff, outData_ff, txDrv_ff;
  ljf_cfg_t nxt_cfg;

  // Every outside input passes two flip-flops before use.
  assign rawPins = {controlModeSelect, shareCsIn, shareSclkIn, hostSerialIn, shareSdoIn, shareIntIn,
    transmitterEnable, transmitLineClock, receiveLineClock, transmitLineData, receiveLineData,
    attenuatorPathSelect, fifoSizeSelLow, fifoSizeSelHigh, transmitLevelSelect, transmitAllOnes,
    remoteLoopbackEn, localLoopbackEn, e3ModeSelect, sonetOrT3RateSelect, receiveEqualizerEn,
    driverMonitorAlarm, digitalSignalLoss, analogSignalLoss, receiveLockLoss, patternLockLoss,
    patternErrorPulse};

  // Synchroniser pair plus one history stage for edge detection.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      prev_ff <= '0;
    end else begin
      syncA_ff <= rawPins;
      syncB_ff <= syncA_ff;
      prev_ff <= syncB_ff;
    end
  end

  // Mode and shared-pin decoding.
  wire hostMode = syncB_ff.modeSel; // RULE8
  wire csActive = hostMode && !syncB_ff.csN; // RULE9
  wire sclkRise = csActive && syncB_ff.sclk && !prev_ff.sclk;
  wire sclkFall = csActive && !syncB_ff.sclk && prev_ff.sclk;
  wire [7:0] rxByte = {shiftIn_ff[6:0], syncB_ff.host_serial_in}; // RULE20
  wire hdrDone = sclkRise && (bitCnt_ff == HDR_LAST);
  wire readStrobe = hdrDone && rxByte[7];
  wire writeStrobe = sclkRise && (bitCnt_ff == FRAME_LAST) && !isRead_ff;
  wire irqStRead = readStrobe && (rxByte[6:0] == REG_IRQ_ST);
  wire flRead = readStrobe && (rxByte[6:0] == REG_ALARM);

  // Serial frame: read/write bit, address, data, MSB first, sampled on rising SCLK.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_ff <= '0;
      shiftIn_ff <= '0;
      addr_ff <= '0;
      isRead_ff <= 1'b0;
    end else if (!csActive) begin
      bitCnt_ff <= '0;
    end else if (sclkRise && bitCnt_ff <= FRAME_LAST) begin // Clocks beyond the frame are ignored.
      bitCnt_ff <= bitCnt_ff + 5'h01; // RULE20
      shiftIn_ff <= rxByte;
      if (hdrDone) begin
        isRead_ff <= rxByte[7];
        addr_ff <= rxByte[6:0];
      end
    end
  end

  // Read data loads after the header and shifts out on falling SCLK.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readShift_ff <= '0;
    end else if (hdrDone) begin
      readShift_ff <= readVal;
    end else if (sclkFall && bitCnt_ff > HDR_LAST + 5'h01) begin
      readShift_ff <= {readShift_ff[6:0], 1'b0};
    end
  end

  // Data out drives only in host mode during the data phase of a read.
  assign hostSerialOut = readShift_ff[7];
  assign hostSerialOutOe = csActive && isRead_ff && (bitCnt_ff > HDR_LAST); // RULE12

  // Configuration register writes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      redund_ff <= REG_RESET;
      irqEn_ff <= REG_RESET;
      txCtl_ff <= REG_RESET;
      rxCtl_ff <= REG_RESET;
      blkCtl_ff <= REG_RESET;
      jaCtl_ff <= REG_RESET;
    end else if (writeStrobe) begin
      unique case (addr_ff)
        REG_REDUND: redund_ff <= rxByte & MASK_REDUND;
        REG_IRQ_EN: irqEn_ff <= rxByte & MASK_CTL;
        REG_TX_CTL: txCtl_ff <= rxByte & MASK_TX;
        REG_RX_CTL: rxCtl_ff <= rxByte & MASK_CTL;
        REG_BLK_CTL: blkCtl_ff <= rxByte & MASK_CTL;
        REG_JA_CTL: jaCtl_ff <= rxByte & MASK_JA;
        default: ;
      endcase
    end
  end

  // Register read mux; unmapped addresses read zero.
  always_comb begin
    unique case (rxByte[6:0])
      REG_REDUND: readVal = redund_ff;
      REG_IRQ_EN: readVal = irqEn_ff;
      REG_IRQ_ST: readVal = irqSt_ff;
      REG_ALARM: readVal = alarmVal;
      REG_TX_CTL: readVal = txCtl_ff;
      REG_RX_CTL: readVal = rxCtl_ff;
      REG_BLK_CTL: readVal = blkCtl_ff;
      REG_JA_CTL: readVal = jaCtl_ff;
      default: readVal = 8'h00;
    endcase
  end

  // Attenuator control from register bits or pins, by mode.
  wire pathTx = hostMode ? jaCtl_ff[B_PATH] : syncB_ff.pathPin; // RULE1
  wire [1:0] sizeSel = hostMode ? {jaCtl_ff[B_JA1], jaCtl_ff[B_JA0]}
    : {syncB_ff.size1, syncB_ff.size0}; // RULE2
  wire jaOn = (sizeSel != JA_OFF);
  assign depth = (sizeSel == JA_16) ? DEPTH_16 : (sizeSel == JA_32) ? DEPTH_32 : DEPTH_128; // RULE19

  // Dejittered read tick divided from the internal reference.
  wire readTick = (divCnt_ff == '0); // RULE7
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_ff <= '0;
    end else begin
      divCnt_ff <= (divCnt_ff == ($clog2(READ_DIV))'(READ_DIV - 1)) ? '0 : divCnt_ff + 1'b1;
    end
  end

  // FIFO writes on the selected line clock edge, reads on the dejittered tick.
  wire lineClk = pathTx ? syncB_ff.transmit_line_clock : syncB_ff.receive_line_clock;
  wire lineClkPrev = pathTx ? prev_ff.transmit_line_clock : prev_ff.receive_line_clock;
  wire lineData = pathTx ? syncB_ff.txData : syncB_ff.rxData;
  wire lineEdge = lineClk && !lineClkPrev;
  assign fill = wrPtr_ff - rdPtr_ff;
  assign fill8 = 8'(fill);
  wire recentre = flRead || (hostMode && jaCtl_ff[B_PNTRST]); // RULE5
  wire doWrite = jaOn && !recentre && lineEdge && (fill8 < depth); // RULE3
  wire doRead = jaOn && !recentre && readTick && (fill8 != 8'h00); // RULE3
  wire nearLimit = jaOn && ((fill8 <= LIMIT_MARGIN) || (fill8 >= depth - LIMIT_MARGIN)); // RULE4

  // Pointer and storage update.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else if (!jaOn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else if (recentre) begin
      rdPtr_ff <= wrPtr_ff - (PW + 1)'(depth >> 1); // RULE5
    end else begin
      wrPtr_ff <= wrPtr_ff + (PW + 1)'(doWrite);
      rdPtr_ff <= rdPtr_ff + (PW + 1)'(doRead);
    end
  end

  always_ff @(posedge clk) begin
    if (doWrite) begin
      fifoMem[wrPtr_ff[PW-1:0]] <= lineData;
    end
  end

  // Output clock and data; bypass the FIFO when the attenuator is off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outClk_ff <= 1'b0;
      outData_ff <= 1'b0;
    end else begin
      outClk_ff <= jaOn ? (divCnt_ff < ($clog2(READ_DIV))'(READ_DIV / 2)) : lineClk; // RULE7
      if (!jaOn) begin
        outData_ff <= lineData;
      end else if (doRead) begin
        outData_ff <= fifoMem[rdPtr_ff[PW-1:0]];
      end
    end
  end
  assign dejitterClock = outClk_ff;
  assign dejitterData = outData_ff;

  // Limit flag is sticky; a new limit hit wins over the clearing read.
  assign nxt_fl = nearLimit || (fl_ff && !flRead); // RULE4 RULE5
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fl_ff <= 1'b0;
    end else begin
      fl_ff <= nxt_fl;
    end
  end

  // Alarm status with loss detectors gated by their disable bits.
  wire dlosEff = syncB_ff.digital_signal_loss && !(hostMode && rxCtl_ff[B_DLOSDIS]);
  wire alosEff = syncB_ff.analog_signal_loss && !(hostMode && rxCtl_ff[B_ALOSDIS]);
  assign alarmVal = {1'b0, syncB_ff.prbsLs, dlosEff, alosEff, fl_ff, syncB_ff.receive_lock_loss, dlosEff || alosEff,
    syncB_ff.driver_monitor_alarm};

  // Saturating pattern error counter.
  wire errPulse = syncB_ff.prbsErr && !prev_ff.prbsErr;
  wire errHitsFull = errPulse && (errCnt_ff == ERR_FULL - 16'h0001);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errCnt_ff <= '0;
    end else if (errPulse && errCnt_ff != ERR_FULL) begin
      errCnt_ff <= errCnt_ff + 16'h0001; // RULE18
    end
  end

  // Interrupt events: alarm rising edges, error pulses and counter saturation.
  wire prevRlos = prev_ff.digital_signal_loss || prev_ff.analog_signal_loss;
  assign irqEvt = {2'b00, errHitsFull, errPulse, nearLimit && !fl_ff, syncB_ff.receive_lock_loss && !prev_ff.receive_lock_loss,
    (syncB_ff.digital_signal_loss || syncB_ff.analog_signal_loss) && !prevRlos, syncB_ff.driver_monitor_alarm && !prev_ff.driver_monitor_alarm}; // RULE18

  // Status clears on read; an event in the same cycle survives.
  assign nxt_irqSt = (irqStRead ? 8'h00 : irqSt_ff) | irqEvt; // RULE14
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqSt_ff <= REG_RESET;
    end else begin
      irqSt_ff <= nxt_irqSt;
    end
  end

  // Enables gate status onto the active-low interrupt pin.
  assign effIe = irqEn_ff & ~(8'(!jaOn) << B_FL); // RULE15 RULE17
  wire irqActive = |(irqSt_ff & effIe); // RULE10
  assign intOutN = !irqActive; // RULE10
  assign intOutOe = hostMode; // RULE12

  // Transmitter drive: host mode ANDs bit and pin, hardware mode uses the pin.
  wire nxt_txDrv = hostMode ? (redund_ff[B_TRANSMITTER_ENABLE] && syncB_ff.txEnPin) : syncB_ff.txEnPin; // RULE13 RULE16
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txDrv_ff <= 1'b0;
    end else begin
      txDrv_ff <= nxt_txDrv;
    end
  end
  assign transmitDriveEn = txDrv_ff;

  // Line configuration: registers in host mode, pins in hardware mode.
  always_comb begin
    if (hostMode) begin
      nxt_cfg = {redund_ff[B_RECEIVER_ENABLE], rxCtl_ff[B_RECEIVE_CLOCK_INVERT], txCtl_ff[B_TRANSMIT_CLOCK_INVERT], rxCtl_ff[B_RECEIVE_MONITOR_GAIN],
        rxCtl_ff[B_SIGNAL_LOSS_MUTE], txCtl_ff[B_TRANSMIT_LEVEL_SELECT], txCtl_ff[B_TRANSMIT_ALL_ONES], blkCtl_ff[B_RLB], blkCtl_ff[B_LLB],
        rxCtl_ff[B_RECEIVE_EQUALIZER_EN], blkCtl_ff[B_E3], blkCtl_ff[B_RATE], blkCtl_ff[B_SRDR], blkCtl_ff[B_PRBSEN],
        txCtl_ff[B_INSPRBS], txCtl_ff[B_TXMON]}; // RULE11
    end else begin
      nxt_cfg = {syncB_ff.host_serial_in, syncB_ff.csN, syncB_ff.sclk, syncB_ff.rxMonPin, syncB_ff.losMutePin,
        syncB_ff.transmit_level_select, syncB_ff.transmit_all_ones, syncB_ff.remote_loopback_en, syncB_ff.local_loopback_en, syncB_ff.receive_equalizer_en, syncB_ff.e3,
        syncB_ff.rate, 1'b0, 1'b0, 1'b0, 1'b0}; // RULE12
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineCfg <= '0;
    end else begin
      lineCfg <= nxt_cfg;
    end
  end

  // Checks on the limit flag, FIFO, interrupt and transmitter behaviour.
  AST_FL_SET: assert property (@(posedge clk) disable iff (rst) nearLimit |=> fl_ff) // RULE4
    else $error("limit flag not set after near-limit fill");
  AST_FL_CLEAR: assert property (@(posedge clk) disable iff (rst)
    flRead && !nearLimit && jaOn ##1 !nearLimit |-> !fl_ff) // RULE5
    else $error("limit flag not cleared by read");
  AST_RECENTRE: assert property (@(posedge clk) disable iff (rst)
    flRead && jaOn && $stable(sizeSel) |=> fill8 == (depth >> 1)) // RULE5
    else $error("FIFO not recentred after limit read");
  AST_NO_OVER: assert property (@(posedge clk) disable iff (rst) fill8 <= depth) // RULE2
    else $error("FIFO fill exceeds selected depth");
  AST_PATH: assert property (@(posedge clk) disable iff (rst)
    doWrite |-> (pathTx ? syncB_ff.transmit_line_clock && !prev_ff.transmit_line_clock : syncB_ff.receive_line_clock && !prev_ff.receive_line_clock)) // RULE1
    else $error("FIFO written from the wrong line clock");
  AST_IRQ_CLR: assert property (@(posedge clk) disable iff (rst)
    irqStRead && irqEvt == 8'h00 |=> irqSt_ff == 8'h00) // RULE14
    else $error("status not cleared by read");
  AST_INT_LOW: assert property (@(posedge clk) disable iff (rst)
    $rose(irqSt_ff[B_RECEIVE_SIGNAL_LOSS]) && irqEn_ff[B_RECEIVE_SIGNAL_LOSS] |-> !intOutN) // RULE10
    else $error("interrupt pin not low for enabled event");
  AST_FIFO_LIMIT_IRQ_EN_OFF: assert property (@(posedge clk) disable iff (rst)
    !jaOn && (irqSt_ff & irqEn_ff & ~(8'h01 << B_FL)) == 8'h00 |-> intOutN) // RULE17
    else $error("limit enable acted while attenuator off");
  AST_TX_OFF: assert property (@(posedge clk) disable iff (rst)
    hostMode && !redund_ff[B_TRANSMITTER_ENABLE] ##1 hostMode |-> !transmitDriveEn) // RULE16
    else $error("transmitter driven with enable bit clear");
  AST_SAT: assert property (@(posedge clk) disable iff (rst) errHitsFull |=> irqSt_ff[B_SAT]) // RULE18
    else $error("saturation status not raised");
  COV_WRITE: cover property (@(posedge clk) disable iff (rst) writeStrobe && addr_ff == REG_JA_CTL);
  COV_FL_READ: cover property (@(posedge clk) disable iff (rst) flRead && fl_ff);
  COV_IRQ: cover property (@(posedge clk) disable iff (rst) $fell(intOutN));
endmodule
`default_nettype wire

/* rtl/ljf_pkg.sv */
// Constants, field layouts and carrier types of the host register bank and jitter FIFO.
// What this block does
// [RULE1] Attenuator sits in receive or transmit path: register bit in host, pin in hardware mode.
// [RULE2] FIFO depth selectable 16, 32 or 128 bits, or attenuator disabled, from two-bit field.
// [RULE3] FIFO written on selected line clock, read on dejittered clock.
// [RULE4] Limit status bit set when fill is within two bits of overflow or underflow.
// [RULE5] Host read of limit status recentres the FIFO and clears the bit.
// [RULE6] Designer should pick the smallest FIFO for delay-sensitive, modest-jitter uses.
// [RULE7] Dejittered clock comes from the internal reference clock, no crystal.
// [RULE8] Mode select high gives host mode, low gives hardware mode.
// [RULE9] Host port is serial clock, data in, data out, chip select and interrupt.
// [RULE10] Interrupt output goes low to report alarm conditions.
// [RULE11] Board grounds hardware configuration inputs in host mode; device ignores them.
// [RULE12] Five shared pins are serial port in host mode, control inputs in hardware mode.
// [RULE13] In host mode the enable pin drives transmitter only while enable bit is one.
// [RULE14] Interrupt status register clears its latched bits when read.
// [RULE15] An enable bit of one lets its condition assert the interrupt; zero suppresses it.
// [RULE16] Clearing the transmitter enable bit turns the transmitter off, outputs floating.
// [RULE17] FIFO limit interrupt enable has no effect while the attenuator is disabled.
// [RULE18] Error counter reaching all ones raises the saturation interrupt when enabled.
// [RULE19] Size field encoding: 00 off, 01 sixteen, 10 thirty-two, 11 one hundred twenty-eight.
// [RULE20] Frame: read/write bit, seven address bits, eight data bits, MSB first, within chip select.
package ljf_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] REG_REDUND = 7'h00;
  localparam logic [6:0] REG_IRQ_EN = 7'h01;
  localparam logic [6:0] REG_IRQ_ST = 7'h02;
  localparam logic [6:0] REG_ALARM = 7'h03;
  localparam logic [6:0] REG_TX_CTL = 7'h04;
  localparam logic [6:0] REG_RX_CTL = 7'h05;
  localparam logic [6:0] REG_BLK_CTL = 7'h06;
  localparam logic [6:0] REG_JA_CTL = 7'h07;
  // Writable bits per register; reserved bits read as zero.
  localparam logic [7:0] MASK_REDUND = 8'h11;
  localparam logic [7:0] MASK_CTL = 8'h3f;
  localparam logic [7:0] MASK_TX = 8'h37;
  localparam logic [7:0] MASK_JA = 8'h1f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Bit positions.
  localparam int B_TRANSMITTER_ENABLE = 0, B_RECEIVER_ENABLE = 4;
  localparam int B_DMO = 0, B_RECEIVE_SIGNAL_LOSS = 1, B_RECEIVE_LOCK_LOSS = 2, B_FL = 3, B_PRBS = 4, B_SAT = 5;
  localparam int B_ANALOG_SIGNAL_LOSS = 4, B_DIGITAL_SIGNAL_LOSS = 5, B_PRBSLS = 6;
  localparam int B_TRANSMIT_LEVEL_SELECT = 0, B_TRANSMIT_CLOCK_INVERT = 1, B_TRANSMIT_ALL_ONES = 2, B_INSPRBS = 4, B_TXMON = 5;
  localparam int B_RECEIVE_EQUALIZER_EN = 0, B_RECEIVE_MONITOR_GAIN = 1, B_SIGNAL_LOSS_MUTE = 2, B_RECEIVE_CLOCK_INVERT = 3, B_ALOSDIS = 4, B_DLOSDIS = 5;
  localparam int B_SRDR = 0, B_RATE = 1, B_E3 = 2, B_LLB = 3, B_RLB = 4, B_PRBSEN = 5;
  localparam int B_JA0 = 0, B_PATH = 1, B_JA1 = 2, B_PNTRST = 3;
  // Size field encoding.
  localparam logic [1:0] JA_OFF = 2'h0;
  localparam logic [1:0] JA_16 = 2'h1;
  localparam logic [1:0] JA_32 = 2'h2;
  localparam logic [7:0] DEPTH_16 = 8'h10;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] LIMIT_MARGIN = 8'h02;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [15:0] ERR_FULL = 16'hffff;
  // Dejittered clock divider from the 20 MHz reference.
  localparam int READ_DIV = 8;

  // Raw pins that cross into the clk domain.
  typedef struct packed {
    logic modeSel, csN, sclk, host_serial_in, rxMonPin, losMutePin, txEnPin;
    logic transmit_line_clock, receive_line_clock, txData, rxData, pathPin, size0, size1;
    logic transmit_level_select, transmit_all_ones, remote_loopback_en, local_loopback_en, e3, rate, receive_equalizer_en;
    logic driver_monitor_alarm, digital_signal_loss, analog_signal_loss, receive_lock_loss, prbsLs, prbsErr;
  } ljf_pins_t;

  // Effective line configuration after the host or hardware mux.
  typedef struct packed {
    logic receiver_enable, receive_clock_invert, transmit_clock_invert, rxMonGain, lossMute, txLevel, txAllOnes, remoteLb;
    logic localLb, rxEqEn, e3Sel, rateSel, singleRail, prbsEn, insPrbs, txMon;
  } ljf_cfg_t;
endpackage

/* test/ljf_host_model.sv */
// Serial host master model that frames register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module ljf_host_model (
  // Clock.
  input wire logic clk,
  // Serial port lines.
  output logic csN,
  output logic sclk,
  output logic host_serial_in,
  input wire logic host_serial_out
);
  // Idle port: chip select high and serial clock parked low outside frames.
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    host_serial_in = 1'b0;
  end

  // One frame of read flag, seven address bits and eight data bits, MSB first.
  task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, adr, wd};
    q = 8'h00;
    @(negedge clk);
    csN = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      host_serial_in = f[k];
      repeat (6) @(negedge clk);
      if (k < 8) q[k] = host_serial_out;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    csN = 1'b1;
    host_serial_in = ~host_serial_in;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* test/ljf_host_regs_bench.sv */
// Self-checking bench for the host register bank and jitter FIFO.
`timescale 1ns/1ps
`default_nettype none
module ljf_host_regs_bench;
  import ljf_pkg::*;
  logic clk, rst, modeSel, csN, sclk, host_serial_in, host_serial_out, sdoOe, intN, intOe, txPin, path, sz0, sz1;
  logic driver_monitor_alarm, digital_signal_loss, analog_signal_loss, receive_lock_loss, plos, perr, txLc, rxLc, txLd, rxLd, djClk, djData, txDrv, lineRun;
  logic [11:0] hw;
  logic [7:0] shadow [8];
  logic [7:0] q;
  ljf_cfg_t cfg;
  time t0;
  int nErrors = 0;
  int comparisons = 0;

  // The serial master sits on the shared pins only in host mode.
  ljf_host_model u_ljf_host_model (.clk(clk), .csN(csN), .sclk(sclk), .host_serial_in(host_serial_in), .host_serial_out(host_serial_out));

  ljf_host_regs u_ljf_host_regs (
    .clk(clk), .rst(rst), .controlModeSelect(modeSel),
    .shareCsIn(modeSel ? csN : hw[0]), .shareSclkIn(modeSel ? sclk : hw[1]),
    .hostSerialIn(modeSel ? host_serial_in : hw[2]), .shareSdoIn(hw[3]), .hostSerialOut(host_serial_out),
    .hostSerialOutOe(sdoOe), .shareIntIn(hw[4]), .intOutN(intN), .intOutOe(intOe),
    .transmitterEnable(txPin), .attenuatorPathSelect(path), .fifoSizeSelLow(sz0),
    .fifoSizeSelHigh(sz1), .transmitLevelSelect(hw[5]), .transmitAllOnes(hw[6]),
    .remoteLoopbackEn(hw[7]), .localLoopbackEn(hw[8]), .e3ModeSelect(hw[9]),
    .sonetOrT3RateSelect(hw[10]), .receiveEqualizerEn(hw[11]), .driverMonitorAlarm(driver_monitor_alarm),
    .digitalSignalLoss(digital_signal_loss), .analogSignalLoss(analog_signal_loss), .receiveLockLoss(receive_lock_loss),
    .patternLockLoss(plos), .patternErrorPulse(perr), .transmitLineClock(txLc),
    .receiveLineClock(rxLc), .transmitLineData(txLd), .receiveLineData(rxLd),
    .dejitterClock(djClk), .dejitterData(djData), .transmitDriveEn(txDrv), .lineCfg(cfg));

  // System clock at 20 MHz.
  always #25 clk = ~clk;

  // Line clocks of 400 ns, offset so their edges never meet the system clock edges.
  initial begin
    #13;
    forever begin
      #200;
      if (lineRun) begin
        rxLc = ~rxLc;
        txLc = rxLc;
        rxLd = 1'($urandom);
        txLd = 1'($urandom);
      end
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Register write and read through the serial master.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_ljf_host_model.xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a);
    u_ljf_host_model.xfer(1'b1, a, 8'h00, q);
  endtask

  // Writable bits of each register; status registers take no writes.
  function automatic logic [7:0] maskOf(input int a);
    case (a)
      0: return MASK_REDUND;
      4: return MASK_TX;
      7: return MASK_JA;
      1, 5, 6: return MASK_CTL;
      default: return 8'h00;
    endcase
  endfunction

  // Line configuration expected from the register shadows or from the pins.
  function automatic ljf_cfg_t expCfg(input logic host);
    if (host) begin
      return {shadow[0][4], shadow[5][3], shadow[4][1], shadow[5][1], shadow[5][2], shadow[4][0],
        shadow[4][2], shadow[6][4], shadow[6][3], shadow[5][0], shadow[6][2], shadow[6][1],
        shadow[6][0], shadow[6][5], shadow[4][4], shadow[4][5]};
    end
    return {hw[2], hw[0], hw[1], hw[3], hw[4], hw[5], hw[6], hw[7], hw[8], hw[11], hw[9], hw[10], 4'h0};
  endfunction

  // Prints the verdict and ends the run.
  task automatic completeRun();
    if (nErrors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: about fifty frames of about nine microseconds fit well inside three milliseconds.
  initial begin
    #3000000;
    nErrors++;
    completeRun();
  end

  // Main sequence.
  initial begin
    clk = 0; rst = 1; modeSel = 1; txPin = 0; path = 0; sz0 = 0; sz1 = 0; hw = 0; lineRun = 0;
    {driver_monitor_alarm, digital_signal_loss, analog_signal_loss, receive_lock_loss, plos, perr, txLc, rxLc, txLd, rxLd} = '0;
    void'($urandom(32'hcdc5a10e));
    repeat (3) @(negedge clk);
    rst = 0;
    repeat (6) @(negedge clk);
    chk({intN, intOe}, 2'b11, "interrupt idle");
    for (int a = 0; a < 9; a++) begin
      rd(a[6:0]);
      chk(q & 8'hf7, REG_RESET, "reset or unmapped value");
    end
    foreach (shadow[a]) begin
      shadow[a] = 8'($urandom);
      wr(a[6:0], shadow[a]);
      shadow[a] &= maskOf(a);
      rd(a[6:0]);
      chk(q & ((a == 2 || a == 3) ? 8'hf7 : 8'hff), shadow[a], "read back");
    end
    repeat (4) @(negedge clk);
    chk(cfg, expCfg(1'b1), "host config");
    hw = 12'($urandom);
    repeat (8) @(negedge clk);
    chk(cfg, expCfg(1'b1), "pins ignored in host mode");
    modeSel = 0;
    repeat (2) begin
      hw = 12'($urandom);
      repeat (8) @(negedge clk);
      chk(cfg, expCfg(1'b0), "hardware config");
      chk({intOe, sdoOe}, 2'b00, "no drive in hardware mode");
    end
    modeSel = 1;
    hw = 0;
    wr(REG_RX_CTL, 8'h00);
    wr(REG_JA_CTL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(REG_REDUND, {7'h00, i[1]});
      txPin = i[0];
      repeat (6) @(negedge clk);
      chk(txDrv, i[1] & i[0], "transmit drive enable");
    end
    wr(REG_IRQ_EN, 8'h02);
    rd(REG_IRQ_ST);
    digital_signal_loss = 1;
    driver_monitor_alarm = 1;
    repeat (8) @(negedge clk);
    chk(intN, 1'b0, "enabled alarm interrupt");
    rd(REG_ALARM);
    chk(q & 8'hf7, 8'h23, "alarm status");
    rd(REG_IRQ_ST);
    chk(q & 8'hf7, 8'h03, "latched status");
    chk(intN, 1'b1, "interrupt after status read");
    rd(REG_IRQ_ST);
    chk(q & 8'hf7, 8'h00, "status cleared by read");
    digital_signal_loss = 0;
    driver_monitor_alarm = 0;
    repeat (6) @(negedge clk);
    // Sources whose enable is clear latch status but leave the pin high.
    {driver_monitor_alarm, perr} = 2'b11;
    repeat (8) @(negedge clk);
    chk(intN, 1'b1, "disabled alarms suppressed");
    rd(REG_IRQ_ST);
    chk(q & 8'hf7, 8'h11, "driver and pattern error status");
    {driver_monitor_alarm, perr} = 2'b00;
    lineRun = 1;
    wr(REG_JA_CTL, {6'h00, 1'b0, JA_16[0]});
    repeat (2) rd(REG_ALARM);
    rd(REG_IRQ_ST);
    wr(REG_IRQ_EN, 8'h08);
    chk(intN, 1'b1, "centred fifo");
    @(posedge djClk);
    t0 = $time;
    @(posedge djClk);
    chk(16'(($time - t0) / 50), 16'(READ_DIV), "dejittered clock period");
    @(negedge clk);
    lineRun = 0;
    repeat (120) @(negedge clk);
    chk(intN, 1'b0, "limit interrupt");
    rd(REG_ALARM);
    chk(q[B_FL], 1'b1, "limit flag");
    lineRun = 1;
    repeat (2) rd(REG_ALARM);
    rd(REG_ALARM);
    chk(q[B_FL], 1'b0, "limit flag after recentre");
    chk(intN, 1'b0, "limit status still latched");
    wr(REG_JA_CTL, {6'h00, JA_OFF});
    chk(intN, 1'b1, "limit enable ignored when off");
    rd(REG_IRQ_ST);
    chk(q[B_FL], 1'b1, "limit status kept while masked");
    lineRun = 0;
    repeat (120) @(negedge clk);
    chk(intN, 1'b1, "no limit interrupt when off");
    // With the attenuator off the output follows the data of the selected path.
    {rxLd, txLd} = 2'b01;
    for (int p = 0; p < 2; p++) begin
      wr(REG_JA_CTL, {6'h00, p[0], 1'b0});
      chk(djData, p[0] ? txLd : rxLd, "bypass data of selected path");
    end
    completeRun();
  end
endmodule
`default_nettype wire
